// [rtl/mlfrp_buf2.sv]
`timescale 1ns/1ps
`default_nettype none

module mlfrp_buf2
  import mlfrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic [1:0] count
);

  mlfrp_buf_s st;
  mlfrp_buf_s next_st;
  logic push;
  logic pop;

  // Honest full and empty straight from the count
  assign in_ready = (st.count != BUF_DEPTH);
  assign out_valid = (st.count != 2'h0);
  assign out_data = st.slot[st.rd];
  assign count = st.count;
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  // Flush wins over a push in the same cycle, the word is stale anyway
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wr] = in_data;
      next_st.wr = ~st.wr;
    end
    if (pop) begin
      next_st.rd = ~st.rd;
    end
    next_st.count = st.count + {1'h0, push} - {1'h0, pop};
    if (flush) begin
      next_st.wr = 1'h0;
      next_st.rd = 1'h0;
      next_st.count = 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_buf_no_overfill;
    @(posedge clk_sys) disable iff (reset)
    (st.count == BUF_DEPTH && !pop && !flush) |=> (st.count == BUF_DEPTH && !in_ready);
  endproperty
  a_buf_no_overfill: assert property (p_buf_no_overfill) // see R19
    else $error("buffer lost or dropped a word while full");

endmodule

`default_nettype wire

// [rtl/mlfrp_pkg.sv]
package mlfrp_pkg;

  // Read opcodes served by this front end
  localparam logic [7:0] OPC_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OPC_QUAD_OUT4 = 8'h6c;
  localparam logic [7:0] OPC_DUAL_IO = 8'hbb;
  localparam logic [7:0] OPC_DUAL_IO4 = 8'hbc;
  localparam logic [7:0] OPC_DTR_DUAL = 8'hbd;
  localparam logic [7:0] OPC_DTR_DUAL4 = 8'hbe;

  // Phase lengths in bits or link clocks
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_3B = 6'h18;
  localparam logic [5:0] ADDR_BITS_4B = 6'h20;
  localparam logic [5:0] MODE_BITS_SDR = 6'h04;
  localparam logic [5:0] MODE_BITS_DTR = 6'h08;
  localparam logic [4:0] QUAD_DUMMY = 5'h08;
  localparam logic [4:0] DUAL_DUMMY_BASE = 5'h04;
  localparam logic [4:0] DTR_DUMMY_BASE = 5'h06;

  // Continuous read select value in mode bits 5:4
  localparam logic [1:0] CONT_SELECT = 2'h2;
  localparam int CONT_SEL_HI = 5;
  localparam int CONT_SEL_LO = 4;

  // Buffer and reset values
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [2:0] CREDIT_MAX = 3'h2;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;
  localparam logic [2:0] SYNC_HIGH = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_MODE = 7'h08,
    ST_DUMMY = 7'h10,
    ST_DATA = 7'h20,
    ST_IGNORE = 7'h40
  } mlfrp_state_e;

  // Decoded read instruction
  typedef struct packed {
    logic ok;
    logic quad;
    logic dual;
    logic dtr;
    logic [5:0] addr_len;
    logic [4:0] dummy;
  } mlfrp_decode_s;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [3:0] lane_m;
    logic [3:0] lane_s;
    mlfrp_state_e state;
    mlfrp_decode_s d;
    logic [7:0] opcode;
    logic cont;
    logic [31:0] addr;
    logic [5:0] cnt;
    logic [7:0] mode_byte;
    logic [31:0] mem_addr;
    logic [1:0] inflight;
    logic [1:0] drop;
    logic [7:0] sh;
    logic [1:0] grp;
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
  } mlfrp_state_s;

  typedef struct packed {
    logic [1:0][7:0] slot;
    logic wr;
    logic rd;
    logic [1:0] count;
  } mlfrp_buf_s;

endpackage

// [rtl/mlfrp_read_path.sv]
// How it works
// [R01] Quad read returns four bits per clock
// [R02] Quad read needs quad lane enable set
// [R03] Quad read waits eight dummy clocks
// [R04] Host releases lanes before first data
// [R05] 6Ch read always takes 32 address bits
// [R06] 6Ch read refused in quad instruction mode
// [R07] Dual read: address and data on two lanes
// [R08] Dual read: mode clocks then latency dummies
// [R09] Mode byte latched, bits five four matter
// [R10] Mode 10 skips opcode on next frame
// [R11] Other mode value restores full opcode
// [R12] Host exits continuous mode with all ones
// [R13] BCh read takes 32 bits, allows continuous
// [R14] BCh read refused in quad instruction mode
// [R15] Double rate: address and data both edges
// [R16] Double rate dummies 6/8/10/12 by latency
// [R17] BDh address width follows address mode
// [R18] BEh read takes 32 bits plus dummies
// [R19] Address advances per byte until deselect
// [R20] Reads ignored while a write is busy
// [R21] Refused quad read keeps lanes released
// [R22] Data most significant bit first, top lane
`timescale 1ns/1ps
`default_nettype none

module mlfrp_read_path
  import mlfrp_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic reset,
  // Link pins, foreign to clk_sys
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  // Status bits, same clock domain
  input wire logic quad_lane_enable_bit,
  input wire logic [1:0] latency_code_field,
  input wire logic four_byte_addr_mode,
  input wire logic quad_instruction_mode,
  input wire logic write_in_progress_flag,
  // Array read request
  output logic mem_rd_valid,
  input wire logic mem_rd_ready,
  output logic [31:0] mem_rd_addr,
  // Array read response
  input wire logic mem_rsp_valid,
  output logic mem_rsp_ready,
  input wire logic [7:0] mem_rsp_data,
  // Observed state
  output logic continuous_read_active,
  output logic [7:0] read_mode_byte,
  output logic read_busy
);

  mlfrp_state_s st;
  mlfrp_state_s next_st;
  mlfrp_decode_s dec_cmd;
  mlfrp_decode_s dec_cont;
  logic rise, fall, frame_start, frame_end, sample_ev, out_ev, fetching, req_hs;
  logic drop_rsp, rsp_to_buf, buf_in_valid, buf_in_ready, buf_out_valid, buf_pop, grp_last;
  logic [1:0] buf_count;
  logic [2:0] credit_used;
  logic [5:0] step, mode_len;
  logic [7:0] op_in, buf_out_data, byte_now, mode_final;

  // Decode one opcode against the current status bits
  function automatic mlfrp_decode_s decode(input logic [7:0] op);
    mlfrp_decode_s d;
    d = '0;
    case (op)
      OPC_QUAD_OUT, OPC_QUAD_OUT4: begin
        d.ok = quad_lane_enable_bit; // see R02 R21
        d.quad = 1'h1;
        d.dummy = QUAD_DUMMY; // see R03
      end
      OPC_DUAL_IO, OPC_DUAL_IO4: begin
        d.ok = 1'h1;
        d.dual = 1'h1;
        d.dummy = DUAL_DUMMY_BASE + {2'h0, latency_code_field, 1'h0}; // see R08
      end
      OPC_DTR_DUAL, OPC_DTR_DUAL4: begin
        d.ok = 1'h1;
        d.dual = 1'h1;
        d.dtr = 1'h1; // see R15
        d.dummy = DTR_DUMMY_BASE + {2'h0, latency_code_field, 1'h0}; // see R16 R18
      end
      default: d.ok = 1'h0;
    endcase
    // Four-byte variants ignore the address mode
    if (four_byte_addr_mode || op == OPC_QUAD_OUT4 || op == OPC_DUAL_IO4 ||
        op == OPC_DTR_DUAL4) begin
      d.addr_len = ADDR_BITS_4B; // see R05 R13 R17 R18
    end else begin
      d.addr_len = ADDR_BITS_3B; // see R17
    end
    if (quad_instruction_mode && (op == OPC_QUAD_OUT4 || op == OPC_DUAL_IO4)) begin
      d.ok = 1'h0; // see R06 R14
    end
    if (write_in_progress_flag) begin
      d.ok = 1'h0; // see R20
    end
    return d;
  endfunction

  // Edges seen only through the second sync stage
  assign rise = st.sclk_s[1] & ~st.sclk_s[2];
  assign fall = ~st.sclk_s[1] & st.sclk_s[2];
  assign frame_start = ~st.cs_s[1] & st.cs_s[2];
  assign frame_end = st.cs_s[1] & ~st.cs_s[2];

  // Double rate waits for the first rise, so the opcode's last
  // falling edge is not taken as an address bit
  assign sample_ev = rise | (st.d.dtr & fall & (st.cnt != 6'h0)); // see R15
  assign out_ev = fall | (st.d.dtr & rise); // see R15

  assign op_in = {st.opcode[6:0], st.lane_s[0]};
  // In a process, so a status bit change alone re-runs the decode
  always_comb begin
    dec_cmd = decode(op_in);
    dec_cont = decode(st.opcode);
  end
  assign step = st.d.dual ? 6'h2 : 6'h1;
  assign mode_len = st.d.dtr ? MODE_BITS_DTR : MODE_BITS_SDR;

  // Prefetch: at most two words in flight, buffered or being dropped
  assign fetching = (st.state == ST_MODE) | (st.state == ST_DUMMY) | (st.state == ST_DATA);
  assign credit_used = {1'h0, st.inflight} + {1'h0, buf_count} + {1'h0, st.drop};
  assign mem_rd_valid = fetching & (credit_used < CREDIT_MAX);
  assign req_hs = mem_rd_valid & mem_rd_ready;

  // Answers to a dead frame are swallowed before the buffer
  assign drop_rsp = (st.drop != 2'h0);
  assign buf_in_valid = mem_rsp_valid & ~drop_rsp;
  assign mem_rsp_ready = drop_rsp | buf_in_ready;
  assign rsp_to_buf = mem_rsp_valid & buf_in_ready & ~drop_rsp;

  // Byte boundary takes a fresh word, else the shifted remainder
  assign grp_last = st.d.quad ? (st.grp == 2'h1) : (st.grp == 2'h3);
  assign buf_pop = (st.state == ST_DATA) & out_ev & (st.grp == 2'h0) & buf_out_valid;
  assign byte_now = (st.grp != 2'h0) ? st.sh :
                    (buf_out_valid ? buf_out_data : UNDERRUN_BYTE);
  assign mode_final = st.d.dtr ? {st.mode_byte[5:0], st.lane_s[1:0]} :
                      {st.mode_byte[1:0], st.lane_s[1:0], 4'h0};

  mlfrp_buf2 u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .flush(frame_end),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(mem_rsp_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data),
    .count(buf_count)
  );

  // Frame sequencer
  always_comb begin
    next_st = st;
    next_st.sclk_s = {st.sclk_s[1:0], spi_sclk};
    next_st.cs_s = {st.cs_s[1:0], spi_cs_n};
    next_st.lane_m = lane_in;
    next_st.lane_s = st.lane_m;
    next_st.inflight = st.inflight + {1'h0, req_hs} - {1'h0, rsp_to_buf};
    if (req_hs) begin
      next_st.mem_addr = st.mem_addr + 32'h1; // see R19
    end
    if (drop_rsp && mem_rsp_valid) begin
      next_st.drop = st.drop - 2'h1;
    end
    case (st.state)
      ST_IDLE: begin
        if (frame_start) begin
          next_st.cnt = 6'h0;
          next_st.addr = 32'h0;
          next_st.grp = 2'h0;
          if (st.cont) begin
            // Continuous mode: the address comes first
            next_st.d = dec_cont;
            next_st.state = dec_cont.ok ? ST_ADDR : ST_IGNORE; // see R10 R13
          end else begin
            next_st.state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (rise) begin
          next_st.opcode = op_in;
          next_st.cnt = st.cnt + 6'h1;
          if (st.cnt == CMD_BITS - 6'h1) begin
            next_st.cnt = 6'h0;
            next_st.d = dec_cmd;
            next_st.state = dec_cmd.ok ? ST_ADDR : ST_IGNORE; // see R20 R21
          end
        end
      end
      ST_ADDR: begin
        if (sample_ev) begin
          if (st.d.dual) begin
            next_st.addr = {st.addr[29:0], st.lane_s[1:0]}; // see R07
          end else begin
            next_st.addr = {st.addr[30:0], st.lane_s[0]}; // see R01
          end
          next_st.cnt = st.cnt + step;
          if (st.cnt + step == st.d.addr_len) begin
            next_st.cnt = 6'h0;
            next_st.mem_addr = next_st.addr;
            next_st.state = st.d.dual ? ST_MODE : ST_DUMMY; // see R08
          end
        end
      end
      ST_MODE: begin
        if (sample_ev) begin
          next_st.mode_byte = {st.mode_byte[5:0], st.lane_s[1:0]}; // see R09
          next_st.cnt = st.cnt + 6'h2;
          if (st.cnt + 6'h2 == mode_len) begin
            next_st.mode_byte = mode_final;
            // Only bits 5:4 count, the low nibble is never looked at
            next_st.cont = (mode_final[CONT_SEL_HI:CONT_SEL_LO] == CONT_SELECT); // see R10 R11
            next_st.cnt = 6'h0;
            next_st.state = ST_DUMMY;
          end
        end
      end
      ST_DUMMY: begin
        // Lanes stay released through the dummies
        if (rise) begin
          next_st.cnt = st.cnt + 6'h1;
          if (st.cnt + 6'h1 == {1'h0, st.d.dummy}) begin
            next_st.cnt = 6'h0;
            next_st.state = ST_DATA; // see R03 R08 R16
          end
        end
      end
      ST_DATA: begin
        if (out_ev) begin
          // First drive lands on a falling edge after the dummies
          next_st.lane_oe = st.d.quad ? 4'hf : 4'h3; // see R04 R01 R07
          if (st.d.quad) begin
            next_st.lane_out = byte_now[7:4]; // see R22 R01
            next_st.sh = {byte_now[3:0], 4'h0};
          end else begin
            next_st.lane_out = {2'h0, byte_now[7:6]}; // see R22 R07
            next_st.sh = {byte_now[5:0], 2'h0};
          end
          next_st.grp = grp_last ? 2'h0 : st.grp + 2'h1; // see R19
        end
      end
      ST_IGNORE: begin
        next_st.lane_oe = 4'h0; // see R21
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    // Deselect ends any frame; words still on the way get dropped
    if (frame_end) begin
      next_st.state = ST_IDLE;
      next_st.lane_oe = 4'h0;
      next_st.grp = 2'h0;
      next_st.drop = next_st.drop + next_st.inflight;
      next_st.inflight = 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.sclk_s <= 3'h0;
      st.cs_s <= SYNC_HIGH;
    end else begin
      st <= next_st;
    end
  end

  assign lane_out = st.lane_out;
  assign lane_oe = st.lane_oe;
  assign mem_rd_addr = st.mem_addr;
  assign continuous_read_active = st.cont;
  assign read_mode_byte = st.mode_byte;
  assign read_busy = (st.state != ST_IDLE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_quad_lanes;
    (st.state == ST_DATA && st.d.quad && lane_oe != 4'h0) |-> (lane_oe == 4'hf);
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) // see R01
    else $error("quad data not on all four lanes");
  property p_qe_gate;
    (st.state == ST_CMD && rise && st.cnt == 6'h7 && !quad_lane_enable_bit &&
     (op_in == OPC_QUAD_OUT || op_in == OPC_QUAD_OUT4)) |=> (st.state == ST_IGNORE);
  endproperty
  a_qe_gate: assert property (p_qe_gate) // see R02
    else $error("quad read taken without quad lane enable");
  property p_quad_dummy;
    (st.state == ST_DUMMY && st.d.quad) |-> (st.d.dummy == 5'h8 && lane_oe == 4'h0);
  endproperty
  a_quad_dummy: assert property (p_quad_dummy) // see R03
    else $error("quad dummy count is not eight");
  property p_ignore_quiet;
    (st.state == ST_IGNORE) |=> (lane_oe == 4'h0);
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) // see R21
    else $error("lanes driven during an ignored read");
  property p_addr32;
    (st.state == ST_ADDR && (st.opcode == OPC_QUAD_OUT4 || st.opcode == OPC_DUAL_IO4 ||
     st.opcode == OPC_DTR_DUAL4)) |-> (st.d.addr_len == 6'h20);
  endproperty
  a_addr32: assert property (p_addr32) // see R05
    else $error("four byte read without 32 address bits");
  property p_qpi_refuse;
    (st.state == ST_CMD && rise && st.cnt == 6'h7 && quad_instruction_mode &&
     (op_in == OPC_QUAD_OUT4 || op_in == OPC_DUAL_IO4)) |=> (st.state == ST_IGNORE);
  endproperty
  a_qpi_refuse: assert property (p_qpi_refuse) // see R06
    else $error("four byte read accepted in quad instruction mode");
  property p_cont_mode;
    (st.state == ST_MODE && next_st.state == ST_DUMMY) |=>
      (st.cont == (st.mode_byte[5:4] == 2'h2));
  endproperty
  a_cont_mode: assert property (p_cont_mode) // see R10
    else $error("continuous flag disagrees with mode bits");
  property p_cont_skip;
    (st.state == ST_IDLE && frame_start && st.cont && !write_in_progress_flag &&
     !quad_instruction_mode) |=> (st.state == ST_ADDR);
  endproperty
  a_cont_skip: assert property (p_cont_skip) // see R10
    else $error("opcode not skipped in continuous mode");
  property p_wip_ignore;
    (st.state == ST_CMD && rise && st.cnt == 6'h7 && write_in_progress_flag) |=>
      (st.state == ST_IGNORE) [*2];
  endproperty
  a_wip_ignore: assert property (p_wip_ignore) // see R20
    else $error("read taken while a write is busy");
  property p_msb_first;
    (st.state == ST_DATA && out_ev && st.grp == 2'h0 && buf_out_valid && st.d.quad &&
     !frame_end) |=> (lane_out == $past(buf_out_data[7:4]));
  endproperty
  a_msb_first: assert property (p_msb_first) // see R22
    else $error("data not sent most significant nibble first");
  property p_addr_advance;
    req_hs |=> (mem_rd_addr == $past(mem_rd_addr) + 32'h1);
  endproperty
  a_addr_advance: assert property (p_addr_advance) // see R19
    else $error("read address did not advance");
  property p_dual_lanes;
    (st.state == ST_DATA && st.d.dual && lane_oe != 4'h0) |-> (lane_oe == 4'h3);
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) // see R07
    else $error("dual data not on lanes zero and one");

endmodule

`default_nettype wire

// [test/mlfrp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module mlfrp_host_model (
  // Clock
  input wire logic clk_sys,
  // Link toward the device
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic [3:0] host_v;
  logic [3:0] host_drv;
  logic [3:0] flip;
  logic [3:0] got;
  logic [3:0] oe_last;
  logic [3:0] oe_or;
  logic [7:0] rx [8];

  // Released lanes wobble, so a stale level never passes for data
  always @(posedge clk_sys) flip <= ~flip;
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_drv & host_v) | (~lane_oe & ~host_drv & flip);

  // Quiet link before the first frame
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    host_v = 4'h0;
    host_drv = 4'h0;
    flip = 4'h5;
    oe_or = 4'h0;
  end

  // One link edge; lanes set mid half so they never move at an edge
  task automatic half(input logic [3:0] v, input logic [3:0] drv);
    host_v = v;
    host_drv = drv;
    repeat (2) @(negedge clk_sys);
    got = lane_in;
    oe_last = lane_oe;
    oe_or = oe_or | lane_oe;
    spi_sclk = ~spi_sclk;
    repeat (2) @(negedge clk_sys);
  endtask

  // Rise then fall
  task automatic clk2(input logic [3:0] v, input logic [3:0] drv);
    half(v, drv);
    half(v, drv);
  endtask

  // End of frame; gap wider than the three cycle minimum
  task automatic deselect();
    repeat (2) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    host_drv = 4'h0;
    repeat (8) @(negedge clk_sys);
  endtask

  // Whole read frame; kind 0 quad out, 1 dual, 2 double rate dual
  task automatic read_frame(input logic [7:0] opc, input bit with_opc, input logic [31:0] addr,
      input int alen, input int kind, input logic [7:0] mode, input int dum, input int n);
    int i;
    int b;
    int k;
    oe_or = 4'h0;
    spi_cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    if (with_opc) for (i = 7; i >= 0; i--) clk2({3'h0, opc[i]}, 4'h1);
    if (kind == 0) for (i = alen - 1; i >= 0; i--) clk2({3'h0, addr[i]}, 4'h1);
    else for (i = alen - 2; i >= 0; i -= 2) begin
      if (kind == 1) clk2({2'h0, addr[i +: 2]}, 4'h3);
      else half({2'h0, addr[i +: 2]}, 4'h3);
    end
    if (kind == 1) for (i = 6; i >= 4; i -= 2) clk2({2'h0, mode[i +: 2]}, 4'h3);
    if (kind == 2) for (i = 6; i >= 0; i -= 2) half({2'h0, mode[i +: 2]}, 4'h3);
    // Lanes let go for all dummies, well before the first data fall
    for (i = 0; i < dum; i++) clk2(4'h0, 4'h0);
    for (b = 0; b < n; b++) begin
      for (k = 0; k < 8; k += (kind == 0) ? 4 : 2) begin
        half(4'h0, 4'h0);
        rx[b] = (kind == 0) ? {rx[b][3:0], got} : {rx[b][5:0], got[1:0]};
        if (kind != 2) half(4'h0, 4'h0);
      end
    end
    deselect();
  endtask

  // Ones on lane zero push the exit bit high
  task automatic exit_frame(input int clocks);
    int i;
    spi_cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (i = 0; i < clocks; i++) clk2(4'h1, 4'h1);
    deselect();
  endtask
endmodule

`default_nettype wire

// [test/test_multi_lane_fast_read_path.sv]
`timescale 1ns/1ps
`default_nettype none

module test_multi_lane_fast_read_path;
  import mlfrp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset;
  logic spi_sclk;
  logic spi_cs_n;
  logic [3:0] lane_in;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  logic quad_lane_enable_bit;
  logic [1:0] latency_code_field;
  logic four_byte_addr_mode;
  logic quad_instruction_mode;
  logic write_in_progress_flag;
  logic mem_rd_valid;
  logic mem_rd_ready;
  logic [31:0] mem_rd_addr;
  logic mem_rsp_valid;
  logic mem_rsp_ready;
  logic [7:0] mem_rsp_data;
  logic continuous_read_active;
  logic [7:0] read_mode_byte;
  logic read_busy;
  logic slow;
  logic [3:0] tick;
  logic [31:0] pend [$];
  int fails;
  int tests_run;
  int i;

  always #20 clk_sys = ~clk_sys;

  mlfrp_read_path dut_u (.clk_sys, .reset, .spi_sclk, .spi_cs_n, .lane_in, .lane_out, .lane_oe,
    .quad_lane_enable_bit, .latency_code_field, .four_byte_addr_mode, .quad_instruction_mode,
    .write_in_progress_flag, .mem_rd_valid, .mem_rd_ready, .mem_rd_addr, .mem_rsp_valid,
    .mem_rsp_ready, .mem_rsp_data, .continuous_read_active, .read_mode_byte, .read_busy);

  mlfrp_host_model host_u (.clk_sys, .spi_sclk, .spi_cs_n, .lane_in, .lane_out, .lane_oe);

  // Array contents: a fold of the address, so a skipped byte shows
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Array model; slow mode throttles both request and answer
  always @(posedge clk_sys) begin
    tick <= tick + 4'h1;
    if (mem_rsp_valid && mem_rsp_ready) void'(pend.pop_front());
    if (mem_rd_valid && mem_rd_ready) pend.push_back(mem_rd_addr);
  end
  always @(negedge clk_sys) begin
    mem_rd_ready = !slow || tick[1];
    mem_rsp_valid = (pend.size() > 0) && (mem_rsp_valid || !slow || tick[2]);
    mem_rsp_data = (pend.size() > 0) ? pat(pend[0]) : 8'h00;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read four bytes; a zero enable means the frame must be refused
  task automatic rd(input logic [7:0] opc, input bit wo, input logic [31:0] a, input int alen,
      input int kind, input logic [7:0] mode, input int dum, input logic [3:0] oe_exp);
    int k;
    host_u.read_frame(opc, wo, a, alen, kind, mode, dum, 4);
    check(32'(oe_exp != 4'h0 ? host_u.oe_last : host_u.oe_or), 32'(oe_exp));
    if (oe_exp != 4'h0) for (k = 0; k < 4; k++) check(32'(host_u.rx[k]), 32'(pat(a + k)));
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #2000000;
    fails++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    quad_lane_enable_bit = 1'b1;
    latency_code_field = 2'h0;
    four_byte_addr_mode = 1'b0;
    quad_instruction_mode = 1'b0;
    write_in_progress_flag = 1'b0;
    mem_rd_ready = 1'b1;
    mem_rsp_valid = 1'b0;
    mem_rsp_data = 8'h00;
    slow = 1'b0;
    tick = 4'h0;
    fails = 0;
    tests_run = 0;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    repeat (6) @(negedge clk_sys);
    rd(OPC_QUAD_OUT, 1, 32'h0012_34fe, 24, 0, 8'h00, 8, 4'hf);
    four_byte_addr_mode = 1'b1;
    rd(OPC_QUAD_OUT, 1, 32'h0123_4567, 32, 0, 8'h00, 8, 4'hf);
    four_byte_addr_mode = 1'b0;
    rd(OPC_QUAD_OUT4, 1, 32'h0abc_deff, 32, 0, 8'h00, 8, 4'hf);
    $display("quad output test over");
    quad_lane_enable_bit = 1'b0;
    rd(OPC_QUAD_OUT, 1, 32'h0000_0010, 24, 0, 8'h00, 8, 4'h0);
    quad_lane_enable_bit = 1'b1;
    quad_instruction_mode = 1'b1;
    rd(OPC_QUAD_OUT4, 1, 32'h0000_0020, 32, 0, 8'h00, 8, 4'h0);
    rd(OPC_DUAL_IO4, 1, 32'h0000_0030, 32, 1, 8'h00, 4, 4'h0);
    quad_instruction_mode = 1'b0;
    write_in_progress_flag = 1'b1;
    rd(OPC_DUAL_IO, 1, 32'h0000_0040, 24, 1, 8'h00, 4, 4'h0);
    write_in_progress_flag = 1'b0;
    $display("refusal test over");
    for (i = 0; i < 4; i++) begin
      latency_code_field = i[1:0];
      rd(OPC_DUAL_IO, 1, 32'h0020_00fd + i, 24, 1, 8'hc7, 4 + 2 * i, 4'h3);
      check(32'(read_mode_byte), 32'hc0);
      check(32'(continuous_read_active), 32'h0);
    end
    $display("dual latency test over");
    latency_code_field = 2'h1;
    rd(OPC_DUAL_IO4, 1, 32'h0200_0010, 32, 1, 8'ha5, 6, 4'h3);
    check(32'(continuous_read_active), 32'h1);
    check(32'(read_mode_byte), 32'ha0);
    rd(OPC_DUAL_IO4, 0, 32'h0300_0020, 32, 1, 8'h10, 6, 4'h3);
    check(32'(continuous_read_active), 32'h0);
    rd(OPC_DUAL_IO, 1, 32'h0040_0030, 24, 1, 8'ha0, 6, 4'h3);
    check(32'(continuous_read_active), 32'h1);
    host_u.exit_frame(16);
    check(32'(continuous_read_active), 32'h0);
    rd(OPC_DUAL_IO, 1, 32'h0050_0040, 24, 1, 8'hf0, 6, 4'h3);
    $display("continuous mode test over");
    for (i = 0; i < 4; i++) begin
      latency_code_field = i[1:0];
      four_byte_addr_mode = (i == 2);
      slow = (i >= 2);
      rd(i[0] ? OPC_DTR_DUAL4 : OPC_DTR_DUAL, 1, 32'h0060_7ffe + i, (i == 0) ? 24 : 32, 2,
         8'h5c, 6 + 2 * i, 4'h3);
      check(32'(read_mode_byte), 32'h5c);
    end
    rd(OPC_DTR_DUAL, 1, 32'h0070_0100, 24, 2, 8'h2c, 12, 4'h3);
    check(32'(continuous_read_active), 32'h1);
    rd(OPC_DTR_DUAL, 0, 32'h0071_0200, 24, 2, 8'hff, 12, 4'h3);
    check(32'(continuous_read_active), 32'h0);
    check(32'(read_busy), 32'h0);
    $display("double rate test over");
    give_verdict();
  end
endmodule

`default_nettype wire
